// *** rtl/scc_pkg.sv ***
// Purpose: Shared constants and types of the smartcard coupler control logic
// Assumes: 25 MHz aclk
// Notes:   Register offsets are byte addresses on the AXI4-Lite slave
package scc_pkg;

	localparam int unsigned CLK_MHZ          = 25;
	localparam int unsigned FILT_MIN_US      = 50;
	localparam int unsigned FILT_MAX_US      = 150;
	// Least and longest filter times convert exactly to aclk cycles, microseconds times CLK_MHZ
	localparam int unsigned FILT_MIN_CYC     = FILT_MIN_US * CLK_MHZ;
	localparam int unsigned FILT_MAX_CYC     = FILT_MAX_US * CLK_MHZ;
	localparam logic [15:0] FILT_RESET       = 16'(FILT_MIN_CYC);

	localparam logic [3:0]  OFF_STATUS       = 4'h0;
	localparam logic [3:0]  OFF_FILTER       = 4'h4;
	localparam logic [3:0]  OFF_CONTROL      = 4'h8;

	localparam int unsigned ST_PRESENT_BIT   = 0;
	localparam int unsigned ST_INT_BIT       = 1;
	localparam int unsigned ST_PROG_BIT      = 2;
	localparam int unsigned ST_VSEL_BIT      = 3;
	localparam int unsigned ST_CLK_LSB       = 4;
	localparam int unsigned ST_CONV_BIT      = 6;
	localparam int unsigned ST_LINE_BIT      = 7;
	localparam int unsigned CTRL_RELEASE_BIT = 0;

	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;

	typedef enum logic [1:0] {CLK_SYNC, CLK_DIV4, CLK_DIV2, CLK_DIV1} scc_clk_t;
	typedef enum logic {MODE_NORMAL, MODE_PROG} scc_mode_t;

	typedef struct packed {
		logic     vsel_5v;
		scc_clk_t clk;
	} scc_cfg_t;

	localparam scc_cfg_t CFG_RESET = '{vsel_5v: 1'b1, clk: CLK_SYNC};

endpackage

// *** rtl/scc_iolink.sv ***
// Purpose: Open-drain bidirectional link between a host line and a card line
// Assumes: Both lines pulled up outside, sampled synchronously
// Notes:   Owner flags stop the link from latching itself low
`timescale 1ns/100ps
`default_nettype none
module scc_iolink
	import scc_pkg::*;
(
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic en,
	input  wire logic host_i,
	input  wire logic card_i,
	output logic      host_o,
	output logic      host_oe,
	output logic      card_o,
	output logic      card_oe
);

	logic host_drv_reg;
	logic card_drv_reg;

	// Frozen while disabled, so the far line keeps its last value
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			host_drv_reg <= 1'b0;
			card_drv_reg <= 1'b0;
		end
		else if (en)
		begin
			host_drv_reg <= !host_i && !card_drv_reg;
			// Host side wins a tie, so the link never pulls both lines at once
			card_drv_reg <= !card_i && !host_drv_reg && (host_i || card_drv_reg);
		end
	end

	assign host_o  = 1'b0;
	assign card_o  = 1'b0;
	assign card_oe = host_drv_reg;
	assign host_oe = card_drv_reg;

	a_no_both_drive : assert property (@(posedge aclk) disable iff (!aresetn)
		!(host_oe && card_oe))
		else $error("link drives both sides low");

endmodule
`default_nettype wire

// *** rtl/scc_clkgen.sv ***
// Purpose: Card clock selector with divide by 1, 2, 4 and daisy-chain output
// Assumes: Clock inputs are slow against aclk and sampled by it
// Notes:   Source change waits until old and new clocks are both low
`timescale 1ns/100ps
`default_nettype none
module scc_clkgen
	import scc_pkg::*;
(
	input  wire logic     aclk,
	input  wire logic     aresetn,
	input  wire logic     async_clock_in,
	input  wire logic     sync_serial_clock_in,
	input  wire logic     selected,
	input  wire scc_clk_t mode,
	output logic          card_clock_out,
	output logic          inverted_clock_out
);

	logic     async_reg;
	logic [1:0] div_reg;
	logic     sync_reg;
	scc_clk_t active_reg;
	logic     switch_now;

	function automatic logic src_of(input scc_clk_t m, input logic a, input logic [1:0] d, input logic s);
		case (m)
			CLK_SYNC: src_of = s;
			CLK_DIV4: src_of = d[1];
			CLK_DIV2: src_of = d[0];
			CLK_DIV1: src_of = a;
			default:  src_of = 1'b0;
		endcase
	endfunction

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			async_reg          <= 1'b0;
			inverted_clock_out <= 1'b1;
		end
		else
		begin
			async_reg          <= async_clock_in;
			inverted_clock_out <= !async_clock_in;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			div_reg <= 2'h0;
		else if (async_clock_in && !async_reg)
			div_reg <= div_reg + 2'h1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			sync_reg <= 1'b0;
		else if (selected)
			sync_reg <= sync_serial_clock_in;
	end

	assign switch_now = (active_reg != mode) && !card_clock_out
		&& !src_of(mode, async_reg, div_reg, sync_reg);

	// Held low through the switch edge so no runt reaches the card
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			active_reg     <= CFG_RESET.clk;
			card_clock_out <= 1'b0;
		end
		else if (switch_now)
		begin
			active_reg     <= mode;
			card_clock_out <= 1'b0;
		end
		else
			card_clock_out <= src_of(active_reg, async_reg, div_reg, sync_reg);
	end

	a_switch_clean : assert property (@(posedge aclk) disable iff (!aresetn)
		$changed(active_reg) |-> !card_clock_out && $past(!card_clock_out))
		else $error("clock source changed while card clock high");

	a_sync_hold : assert property (@(posedge aclk) disable iff (!aresetn)
		!selected ##1 !selected && active_reg == CLK_SYNC && $past(active_reg) == CLK_SYNC
			|=> $stable(card_clock_out))
		else $error("synchronous card clock moved while deselected");

	a_inv_follow : assert property (@(posedge aclk) disable iff (!aresetn)
		async_clock_in |=> !inverted_clock_out)
		else $error("daisy-chain clock not inverted");

endmodule
`default_nettype wire

// *** rtl/scc_coupler.sv ***
// Purpose: Host pin logic of a smartcard coupler with status on AXI4-Lite
// Assumes: All pins synchronous to aclk; pullups and card supply outside
// Notes:   Two-way pins appear as input, output and output enable
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Power request starts converter normally, selects card supply voltage in programming.
// - Card insertion or extraction pulls the interrupt line low.
// - Interrupt released on select rising edge or power request rising edge.
// - Ready pin low at select falling edge enters programming mode.
// - Ready pin released means normal mode; device drives it as status.
// - Selected normal: status is converter state or card presence per power request.
// - Deselected coupler ignores power, reset, serial, sync clock and aux inputs; the logic still releases the interrupt on a power request rising edge.
// - Host reset passes to card reset while selected, held otherwise.
// - Serial line linked both ways while selected, held while deselected.
// - Aux lines linked like serial line, never used for programming.
// - Card aux lines mirror card serial line behaviour with their host pair.
// - Inverted copy of the asynchronous clock drives the chain output.
// - Asynchronous source gives card clock divided by one, two or four.
// - Synchronous source follows while selected, holds level while deselected.
// - Voltage and clock selection programmed by power, reset and serial with ready low.
// - Detect polarity select chooses which switch level means card present.
// - Detect changes filtered 50 to 150 microseconds before reporting; the filter register takes any 16-bit count.
// - Selections captured at select rising edge; reset gives 5 V, sync clock.
// - Truth table maps power to voltage and reset/serial to clock source.
// - Clock source or ratio changes without glitches on card clock.
module scc_coupler
	import scc_pkg::*;
#(
	parameter int unsigned ADDR_W = 4
)
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              coupler_select_n,
	input  wire logic              converter_power_request,
	input  wire logic              converter_ok,
	output logic                   converter_enable,
	output logic                   card_supply_5v,
	input  wire logic              ready_mode_pin_i,
	output logic                   ready_mode_pin_o,
	output logic                   ready_mode_pin_oe,
	input  wire logic              card_change_int_n_i,
	output logic                   card_change_int_n_o,
	output logic                   card_change_int_n_oe,
	input  wire logic              host_reset_in,
	output logic                   card_reset_out,
	input  wire logic              host_serial_i,
	output logic                   host_serial_o,
	output logic                   host_serial_oe,
	input  wire logic              card_serial_line_i,
	output logic                   card_serial_line_o,
	output logic                   card_serial_line_oe,
	input  wire logic [1:0]        host_aux_i,
	output logic [1:0]             host_aux_o,
	output logic [1:0]             host_aux_oe,
	input  wire logic [1:0]        card_aux_i,
	output logic [1:0]             card_aux_o,
	output logic [1:0]             card_aux_oe,
	input  wire logic              async_clock_in,
	input  wire logic              sync_serial_clock_in,
	output logic                   inverted_clock_out,
	output logic                   card_clock_out,
	input  wire logic              card_detect_switch,
	input  wire logic              detect_polarity_select
);

	scc_mode_t   mode_reg;
	scc_cfg_t    cfg_reg;
	logic        sel_prev_reg;
	logic        pwr_prev_reg;
	logic        sel_fall;
	logic        sel_rise;
	logic        pwr_rise;
	logic        enter_prog;
	logic        normal_sel;
	logic        present_raw;
	logic        present_reg;
	logic [15:0] filt_cnt_reg;
	logic [15:0] filt_reg;
	logic        det_change;
	logic        int_reg;
	logic        sw_release_reg;
	logic        aw_ok_reg;
	logic        w_ok_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0]  wstrb_reg;
	logic        do_write;
	logic [31:0] status_word;

	// One history flop per input so each edge is one event
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sel_prev_reg <= 1'b1;
			pwr_prev_reg <= 1'b0;
		end
		else
		begin
			sel_prev_reg <= coupler_select_n;
			pwr_prev_reg <= converter_power_request;
		end
	end

	assign sel_fall   = !coupler_select_n && sel_prev_reg;
	assign sel_rise   = coupler_select_n && !sel_prev_reg;
	assign pwr_rise   = converter_power_request && !pwr_prev_reg;
	assign enter_prog = sel_fall && !ready_mode_pin_i && mode_reg == MODE_NORMAL;
	assign normal_sel = !coupler_select_n && mode_reg == MODE_NORMAL;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mode_reg <= MODE_NORMAL;
			cfg_reg  <= CFG_RESET;
		end
		else
		begin
			case (mode_reg)
				MODE_NORMAL:
				begin
					if (enter_prog)
						mode_reg <= MODE_PROG;
				end
				MODE_PROG:
				begin
					if (sel_rise)
					begin
						mode_reg        <= MODE_NORMAL;
						cfg_reg.vsel_5v <= converter_power_request;
						case ({host_reset_in, host_serial_i})
							2'h0:    cfg_reg.clk <= CLK_SYNC;
							2'h1:    cfg_reg.clk <= CLK_DIV4;
							2'h3:    cfg_reg.clk <= CLK_DIV2;
							2'h2:    cfg_reg.clk <= CLK_DIV1;
							default: cfg_reg.clk <= CLK_SYNC;
						endcase
					end
				end
				default: mode_reg <= MODE_NORMAL;
			endcase
		end
	end

	assign card_supply_5v = cfg_reg.vsel_5v;

	// Host levels pass only while selected in normal mode
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			converter_enable <= 1'b0;
			card_reset_out   <= 1'b0;
		end
		else if (normal_sel)
		begin
			converter_enable <= converter_power_request;
			card_reset_out   <= host_reset_in;
		end
	end

	// Never drive on the select edge, the host may be forcing it low
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ready_mode_pin_oe <= 1'b0;
			ready_mode_pin_o  <= 1'b0;
		end
		else
		begin
			ready_mode_pin_oe <= normal_sel && !sel_fall;
			ready_mode_pin_o  <= converter_power_request ? converter_ok : present_reg;
		end
	end

	assign present_raw = card_detect_switch ^ detect_polarity_select;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			present_reg  <= 1'b0;
			filt_cnt_reg <= 16'h0;
		end
		else if (present_raw == present_reg)
			filt_cnt_reg <= 16'h0;
		else if (filt_cnt_reg + 16'h1 >= filt_reg)
		begin
			present_reg  <= present_raw;
			filt_cnt_reg <= 16'h0;
		end
		else
			filt_cnt_reg <= filt_cnt_reg + 16'h1;
	end

	assign det_change = (present_raw != present_reg) && (filt_cnt_reg + 16'h1 >= filt_reg);

	// A card change in the release cycle still pulls the line
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			int_reg <= 1'b0;
		else if (det_change)
			int_reg <= 1'b1;
		else if (sel_rise || pwr_rise || sw_release_reg)
			int_reg <= 1'b0;
	end

	assign card_change_int_n_o  = 1'b0;
	assign card_change_int_n_oe = int_reg;

	scc_iolink u_serial
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.en      (normal_sel),
		.host_i  (host_serial_i),
		.card_i  (card_serial_line_i),
		.host_o  (host_serial_o),
		.host_oe (host_serial_oe),
		.card_o  (card_serial_line_o),
		.card_oe (card_serial_line_oe)
	);

	// Aux links ignore programming mode entirely
	for (genvar i = 0; i < 2; i++)
	begin : g_aux
		scc_iolink u_aux
		(
			.aclk    (aclk),
			.aresetn (aresetn),
			.en      (!coupler_select_n),
			.host_i  (host_aux_i[i]),
			.card_i  (card_aux_i[i]),
			.host_o  (host_aux_o[i]),
			.host_oe (host_aux_oe[i]),
			.card_o  (card_aux_o[i]),
			.card_oe (card_aux_oe[i])
		);
	end

	scc_clkgen u_clkgen
	(
		.aclk                 (aclk),
		.aresetn              (aresetn),
		.async_clock_in       (async_clock_in),
		.sync_serial_clock_in (sync_serial_clock_in),
		.selected             (normal_sel),
		.mode                 (cfg_reg.clk),
		.card_clock_out       (card_clock_out),
		.inverted_clock_out   (inverted_clock_out)
	);

	// AXI4-Lite: address and data latched independently, one write at a time
	assign s_axi_awready = !aw_ok_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_ok_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_write      = aw_ok_reg && w_ok_reg && !s_axi_bvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_ok_reg  <= 1'b0;
			w_ok_reg   <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg  <= 32'h0;
			wstrb_reg  <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_ok_reg  <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			else if (do_write)
				aw_ok_reg <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_ok_reg  <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			else if (do_write)
				w_ok_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			filt_reg       <= FILT_RESET;
			sw_release_reg <= 1'b0;
			s_axi_bvalid   <= 1'b0;
			s_axi_bresp    <= RESP_OKAY;
		end
		else
		begin
			sw_release_reg <= 1'b0;
			if (do_write)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= RESP_OKAY;
				case (awaddr_reg)
					ADDR_W'(OFF_STATUS): ;
					ADDR_W'(OFF_FILTER):
					begin
						if (wstrb_reg[0])
							filt_reg[7:0] <= wdata_reg[7:0];
						if (wstrb_reg[1])
							filt_reg[15:8] <= wdata_reg[15:8];
					end
					ADDR_W'(OFF_CONTROL):
						sw_release_reg <= wstrb_reg[0] && wdata_reg[CTRL_RELEASE_BIT];
					default: s_axi_bresp <= RESP_SLVERR;
				endcase
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_comb
	begin
		status_word                   = 32'h0;
		status_word[ST_PRESENT_BIT]   = present_reg;
		status_word[ST_INT_BIT]       = int_reg;
		status_word[ST_PROG_BIT]      = mode_reg == MODE_PROG;
		status_word[ST_VSEL_BIT]      = cfg_reg.vsel_5v;
		status_word[ST_CLK_LSB +: 2]  = cfg_reg.clk;
		status_word[ST_CONV_BIT]      = converter_enable;
		status_word[ST_LINE_BIT]      = !card_change_int_n_i;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= RESP_OKAY;
			case (s_axi_araddr)
				ADDR_W'(OFF_STATUS):  s_axi_rdata <= status_word;
				ADDR_W'(OFF_FILTER):  s_axi_rdata <= {16'h0, filt_reg};
				ADDR_W'(OFF_CONTROL): s_axi_rdata <= 32'h0;
				default:
				begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	sequence s_prog_entry;
		sel_fall && !ready_mode_pin_i && mode_reg == MODE_NORMAL;
	endsequence

	a_prog_entry : assert property (@(posedge aclk) disable iff (!aresetn)
		s_prog_entry |=> mode_reg == MODE_PROG && !ready_mode_pin_oe)
		else $error("programming mode not entered");

	a_prog_capture : assert property (@(posedge aclk) disable iff (!aresetn)
		mode_reg == MODE_PROG && sel_rise |=> mode_reg == MODE_NORMAL
			&& cfg_reg.vsel_5v == $past(converter_power_request)
			&& (cfg_reg.clk == CLK_SYNC) == ($past(host_reset_in) == 1'b0 && $past(host_serial_i) == 1'b0))
		else $error("programming values not captured");

	a_int_on_change : assert property (@(posedge aclk) disable iff (!aresetn)
		det_change |=> card_change_int_n_oe && !card_change_int_n_o)
		else $error("card change did not pull interrupt low");

	a_int_release : assert property (@(posedge aclk) disable iff (!aresetn)
		(sel_rise || pwr_rise) && !det_change |=> !card_change_int_n_oe)
		else $error("interrupt not released");

	a_reset_hold : assert property (@(posedge aclk) disable iff (!aresetn)
		coupler_select_n ##1 coupler_select_n |-> $stable(card_reset_out))
		else $error("card reset moved while deselected");

	a_ready_status : assert property (@(posedge aclk) disable iff (!aresetn)
		normal_sel && !sel_fall ##1 normal_sel |-> ready_mode_pin_oe
			&& ready_mode_pin_o == ($past(converter_power_request) ? $past(converter_ok) : $past(present_reg)))
		else $error("ready status wrong");

	a_conv_gate : assert property (@(posedge aclk) disable iff (!aresetn)
		mode_reg == MODE_PROG |=> $stable(converter_enable))
		else $error("converter switched during programming");

	a_filter_time : assert property (@(posedge aclk) disable iff (!aresetn)
		$changed(present_reg) |-> $past(filt_cnt_reg) + 16'h1 >= $past(filt_reg))
		else $error("detect reported before filter time");

endmodule
`default_nettype wire

// *** test/scc_far_model.sv ***
// Purpose: Host and card pin side of the coupler, resolving every shared wire
// Assumes: All shared lines have pull-ups; parties only pull low, except the coupler's ready status drive
// Notes:   Released lines float high, so a stale value never survives
`timescale 1ns/100ps
`default_nettype none
module scc_far_model
(
	input  wire logic       ready_low,
	input  wire logic       ready_o,
	input  wire logic       ready_oe,
	input  wire logic       int_oe,
	input  wire logic       host_ser_low,
	input  wire logic       host_ser_oe,
	input  wire logic       card_ser_low,
	input  wire logic       card_ser_oe,
	input  wire logic [1:0] host_aux_low,
	input  wire logic [1:0] host_aux_oe,
	input  wire logic [1:0] card_aux_low,
	input  wire logic [1:0] card_aux_oe,
	output logic            ready_i,
	output logic            int_i,
	output logic            host_ser_i,
	output logic            card_ser_i,
	output logic [1:0]      host_aux_i,
	output logic [1:0]      card_aux_i
);
	// Host forcing low wins over the status drive
	assign ready_i = ready_low ? 1'b0 : (ready_oe ? ready_o : 1'b1);
	assign int_i = !int_oe;
	assign host_ser_i = !(host_ser_low || host_ser_oe);
	assign card_ser_i = !(card_ser_low || card_ser_oe);
	assign host_aux_i = ~(host_aux_low | host_aux_oe);
	assign card_aux_i = ~(card_aux_low | card_aux_oe);
endmodule
`default_nettype wire

// *** test/tb.sv ***
// Purpose: Self-checking bench of the coupler pin logic and its status bus
// Assumes: Filter shortened to 4 cycles through its register
// Notes:   Handshakes sampled at the falling edge, driven after the rising edge
`timescale 1ns/100ps
`default_nettype none
module tb;
	import scc_pkg::*;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, converter_enable, card_supply_5v;
	logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic coupler_select_n = 1, converter_power_request = 0, converter_ok = 0, host_reset_in = 0;
	logic ready_mode_pin_i, ready_mode_pin_o, ready_mode_pin_oe, card_change_int_n_i;
	logic card_change_int_n_o, card_change_int_n_oe, card_reset_out, host_serial_i, host_serial_o;
	logic host_serial_oe, card_serial_line_i, card_serial_line_o, card_serial_line_oe;
	logic [1:0] host_aux_i, host_aux_o, host_aux_oe, card_aux_i, card_aux_o, card_aux_oe;
	logic async_clock_in = 0, sync_serial_clock_in = 0, inverted_clock_out, card_clock_out;
	logic card_detect_switch = 0, detect_polarity_select = 0, a_d = 0;
	logic ready_low = 0, host_ser_low = 0, card_ser_low = 0;
	logic [1:0] host_aux_low = 0, card_aux_low = 0, ph = 0;
	logic [31:0] d;
	logic [1:0] r;
	int num_errors = 0, n_tests = 0;

	scc_coupler uut (.*);
	scc_far_model far (.ready_low(ready_low), .ready_o(ready_mode_pin_o), .ready_oe(ready_mode_pin_oe),
		.int_oe(card_change_int_n_oe), .host_ser_low(host_ser_low), .host_ser_oe(host_serial_oe),
		.card_ser_low(card_ser_low), .card_ser_oe(card_serial_line_oe), .host_aux_low(host_aux_low),
		.host_aux_oe(host_aux_oe), .card_aux_low(card_aux_low), .card_aux_oe(card_aux_oe),
		.ready_i(ready_mode_pin_i), .int_i(card_change_int_n_i), .host_ser_i(host_serial_i),
		.card_ser_i(card_serial_line_i), .host_aux_i(host_aux_i), .card_aux_i(card_aux_i));

	always #20 aclk = ~aclk;
	// Async clock at a quarter of aclk
	always @(posedge aclk)
	begin
		ph <= ph + 2'd1;
		a_d <= async_clock_in;
		if (ph[0])
			async_clock_in <= ~async_clock_in;
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic axw(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic pa, pw, ta, tw;
		pa = 1;
		pw = 1;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (pa || pw)
		begin
			@(negedge aclk);
			ta = pa && s_axi_awready;
			tw = pw && s_axi_wready;
			@(posedge aclk);
			if (ta)
			begin
				s_axi_awvalid <= 0;
				pa = 0;
			end
			if (tw)
			begin
				s_axi_wvalid <= 0;
				pw = 0;
			end
		end
		do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
		rs = s_axi_bresp;
		@(posedge aclk);
		s_axi_bready <= 0;
	endtask
	task automatic axr(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(negedge aclk); while (s_axi_arready !== 1'b1);
		@(posedge aclk);
		s_axi_arvalid <= 0;
		do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		rs = s_axi_rresp;
		@(posedge aclk);
		s_axi_rready <= 0;
	endtask

	task automatic t_regs;
		axr(OFF_STATUS, d, r);
		chk(d[5:3], 3'b001);
		axr(OFF_FILTER, d, r);
		chk(d, 32'(FILT_RESET));
		axr(4'hc, d, r);
		chk(r, RESP_SLVERR);
		axw(4'hc, 32'h1, r);
		chk(r, RESP_SLVERR);
		axw(OFF_FILTER, 32'h4, r);
		chk(r, RESP_OKAY);
		$display("test regs done");
	endtask
	task automatic t_detect;
		card_detect_switch <= 1;
		cyc(2);
		card_detect_switch <= 0;
		cyc(8);
		@(negedge aclk) chk(card_change_int_n_oe, 1'b0);
		card_detect_switch <= 1;
		cyc(10);
		@(negedge aclk) chk(card_change_int_n_oe, 1'b1);
		axr(OFF_STATUS, d, r);
		chk(d[ST_PRESENT_BIT], 1'b1);
		coupler_select_n <= 0;
		cyc(3);
		coupler_select_n <= 1;
		cyc(3);
		@(negedge aclk) chk(card_change_int_n_oe, 1'b0);
		detect_polarity_select <= 1;
		cyc(10);
		@(negedge aclk) chk(card_change_int_n_oe, 1'b1);
		axr(OFF_STATUS, d, r);
		chk(d[ST_PRESENT_BIT], 1'b0);
		coupler_select_n <= 0;
		converter_ok <= 1;
		cyc(3);
		converter_power_request <= 1;
		cyc(3);
		@(negedge aclk) chk({card_change_int_n_oe, converter_enable}, 2'b01);
		chk({ready_mode_pin_oe, ready_mode_pin_o}, 2'b11);
		converter_ok <= 0;
		card_detect_switch <= 0;
		cyc(10);
		@(negedge aclk) chk(ready_mode_pin_o, 1'b0);
		converter_power_request <= 0;
		cyc(3);
		@(negedge aclk) chk(ready_mode_pin_o, 1'b1);
		axr(OFF_STATUS, d, r);
		chk({d[ST_LINE_BIT], d[ST_INT_BIT]}, 2'b11);
		axw(OFF_CONTROL, 32'h1, r);
		@(negedge aclk) chk(card_change_int_n_oe, 1'b0);
		$display("test detect done");
	endtask
	task automatic t_pins;
		host_reset_in <= 1;
		sync_serial_clock_in <= 1;
		cyc(3);
		@(negedge aclk) chk({card_reset_out, card_clock_out}, 2'b11);
		coupler_select_n <= 1;
		cyc(2);
		host_reset_in <= 0;
		sync_serial_clock_in <= 0;
		converter_power_request <= 1;
		host_ser_low <= 1;
		cyc(3);
		@(negedge aclk) chk({card_reset_out, card_clock_out, converter_enable, card_serial_line_oe}, 4'b1100);
		host_ser_low <= 0;
		converter_power_request <= 0;
		coupler_select_n <= 0;
		cyc(3);
		host_ser_low <= 1;
		cyc(3);
		@(negedge aclk) chk({card_serial_line_oe, card_serial_line_i}, 2'b10);
		host_ser_low <= 0;
		card_ser_low <= 1;
		card_aux_low <= 2'b10;
		host_aux_low <= 2'b01;
		cyc(3);
		@(negedge aclk) chk({card_serial_line_oe, host_serial_oe, host_aux_oe, card_aux_oe}, 6'b011001);
		card_ser_low <= 0;
		card_aux_low <= 0;
		host_aux_low <= 0;
		coupler_select_n <= 1;
		cyc(3);
		$display("test pins done");
	endtask
	task automatic t_prog;
		// power, reset, serial, expected clock field
		logic [4:0] tab [4] = '{5'b10000, 5'b00101, 5'b11011, 5'b01110};
		foreach (tab[i])
		begin
			ready_low <= 1;
			cyc(2);
			coupler_select_n <= 0;
			cyc(3);
			{converter_power_request, host_reset_in} <= tab[i][4:3];
			host_ser_low <= ~tab[i][2];
			axr(OFF_STATUS, d, r);
			chk(d[ST_PROG_BIT], 1'b1);
			coupler_select_n <= 1;
			cyc(3);
			ready_low <= 0;
			host_ser_low <= 0;
			axr(OFF_STATUS, d, r);
			chk(d[5:3], {tab[i][1:0], tab[i][4]});
			@(negedge aclk) chk(card_supply_5v, tab[i][4]);
		end
		$display("test prog done");
	endtask
	task automatic t_clock;
		int n;
		logic p;
		n = 0;
		p = 1'b1;
		repeat (64)
		begin
			@(negedge aclk);
			chk(inverted_clock_out, !a_d);
			if (card_clock_out && !p)
				n++;
			p = card_clock_out;
		end
		chk(n >= 7 && n <= 9, 1'b1);
		$display("test clock done");
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		#(40 * 20000);
		num_errors++;
		end_of_test;
	end
	initial
	begin
		cyc(3);
		aresetn <= 1;
		t_regs;
		t_detect;
		t_pins;
		t_prog;
		t_clock;
		end_of_test;
	end
endmodule
`default_nettype wire
